// ---- uart_shadow_defines.vh ----
/*
 * Register offsets, field positions and reset values for the UART
 * receive-level, software-reset and request-to-send mirror registers.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef UART_SHADOW_DEFINES_VH
`define UART_SHADOW_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RX_LEVEL_OFFSET      8'h84
`define SOFT_RESET_OFFSET    8'h88
`define RTS_MIRROR_OFFSET    8'h8c

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define RX_LEVEL_MSB         4
`define TX_FLUSH_BIT         2
`define RX_FLUSH_BIT         1
`define FULL_RESET_BIT       0
`define RTS_MIRROR_BIT       0
`define FCR_RX_FLUSH_BIT     1
`define FCR_TX_FLUSH_BIT     2
`define MCR_RTS_BIT          1
`define RX_LEVEL_RESET       5'h00
`define RTS_RESET            1'b0

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ---- reset_sync.v ----
/*
 * Reset synchroniser: asserts asynchronously, releases on the clock.
 * Assumes CLK runs while reset is released.
 */
`timescale 1ns/1ps

module reset_sync (
    input  wire clk,
    input  wire async_rstn,
    output wire sync_rstn
);

    reg stage1;
    reg stage2;

    // Only stage2 reads stage1
    always @(posedge clk or negedge async_rstn) begin
        if (!async_rstn) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= 1'b1;
            stage2 <= stage1;
        end
    end

    assign sync_rstn = stage2;

endmodule // reset_sync

// ---- uart_shadow_regs.v ----
/*
 * AXI4-Lite slave for receive FIFO level, software reset control and
 * request-to-send mirror registers of a UART.
 * Assumes the FIFO level and control bits come from the rest of the UART
 * on the same clock; flush outputs are one-cycle pulses, and a soft reset holds the reset output low for four cycles.
 *
// Summary of operation
// - Receive FIFO entry count, five bits, read-only
// - Bit two flushes transmit FIFO when present
// - Bit one flushes receive FIFO when present
// - Bit zero fully resets, release synchronised
// - RTS mirror reads and writes modem control
 */
`timescale 1ns/1ps
`include "uart_shadow_defines.vh"

module uart_shadow_regs #(
    parameter FIFO_PRESENT = 1
) (
    input  wire        CLK,
    input  wire        RSTN,
    input  wire [7:0]  AWADDR,
    input  wire        AWVALID,
    output reg         AWREADY,
    input  wire [31:0] WDATA,
    input  wire [3:0]  WSTRB,
    input  wire        WVALID,
    output reg         WREADY,
    output reg  [1:0]  BRESP,
    output reg         BVALID,
    input  wire        BREADY,
    input  wire [7:0]  ARADDR,
    input  wire        ARVALID,
    output reg         ARREADY,
    output reg  [31:0] RDATA,
    output reg  [1:0]  RRESP,
    output reg         RVALID,
    input  wire        RREADY,
    input  wire [4:0]  RX_FIFO_COUNT,
    input  wire        RTS_CONTROL,
    output reg         RTS_WRITE,
    output reg         RTS_WRITE_VALUE,
    output reg         TX_FIFO_FLUSH,
    output reg         RX_FIFO_FLUSH,
    output reg         UART_RSTN
);

    // ----------------------------------------------------------------
    // Reset combination
    // ----------------------------------------------------------------
    // Full reset request is held until the combined reset takes it.
    reg  full_reset_req;
    wire combined_rstn;
    wire rstn;

    assign combined_rstn = RSTN & ~full_reset_req;

    reset_sync u_reset_sync (
        .clk        (CLK),
        .async_rstn (combined_rstn),
        .sync_rstn  (rstn)
    );

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    reg        aw_held;
    reg        w_held;
    reg [7:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;

    wire aw_take = AWVALID & AWREADY;
    wire w_take  = WVALID & WREADY;
    wire have_aw = aw_held | aw_take;
    wire have_w  = w_held | w_take;
    wire do_wr   = have_aw & have_w & ~BVALID;
    wire [7:0]  wr_addr = aw_held ? aw_addr : AWADDR;
    wire [31:0] wr_data = w_held ? w_data : WDATA;
    wire [3:0]  wr_strb = w_held ? w_strb : WSTRB;

    function known_addr;
        input [7:0] a;
        begin
            known_addr = (a == `RX_LEVEL_OFFSET) ||
                         (a == `SOFT_RESET_OFFSET) ||
                         (a == `RTS_MIRROR_OFFSET);
        end
    endfunction

    wire wr_soft = do_wr && wr_addr == `SOFT_RESET_OFFSET && wr_strb[0];
    wire wr_rts  = do_wr && wr_addr == `RTS_MIRROR_OFFSET && wr_strb[0];

    // FIFO-absent builds ignore the flush bits entirely
    function flush_bit;
        input [31:0] data;
        input integer pos;
        begin
            flush_bit = (FIFO_PRESENT != 0) && data[pos];
        end
    endfunction

    // ----------------------------------------------------------------
    // Software full reset
    // ----------------------------------------------------------------
    // The request flop sits outside the reset it raises and drops only
    // once the synchronised reset is low; clearing it from its own reset
    // would give a glitch-wide pulse through an asynchronous loop.
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            full_reset_req <= 1'b0;
        end else if (!rstn) begin
            full_reset_req <= 1'b0;
        end else if (wr_soft && wr_data[`FULL_RESET_BIT]) begin
            full_reset_req <= 1'b1;
        end
    end

    always @(posedge CLK or negedge rstn) begin
        if (!rstn) begin
            AWREADY         <= 1'b0;
            WREADY          <= 1'b0;
            BVALID          <= 1'b0;
            BRESP           <= `RESP_OKAY;
            aw_held         <= 1'b0;
            w_held          <= 1'b0;
            aw_addr         <= 8'h00;
            w_data          <= 32'h00000000;
            w_strb          <= 4'h0;
            TX_FIFO_FLUSH   <= 1'b0;
            RX_FIFO_FLUSH   <= 1'b0;
            RTS_WRITE       <= 1'b0;
            RTS_WRITE_VALUE <= `RTS_RESET;
        end else begin
            // Each ready drops for a cycle after a take, so a held beat is
            // never overwritten before its response has gone out.
            AWREADY <= ~have_aw & ~(AWREADY & AWVALID);
            WREADY  <= ~have_w & ~(WREADY & WVALID);
            if (aw_take && !do_wr) begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end else if (do_wr) begin
                aw_held <= 1'b0;
            end
            if (w_take && !do_wr) begin
                w_held <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end else if (do_wr) begin
                w_held <= 1'b0;
            end
            if (do_wr) begin
                BVALID <= 1'b1;
                BRESP  <= known_addr(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
            // Pulses last one cycle and clear themselves
            TX_FIFO_FLUSH <= wr_soft &&
                             flush_bit(wr_data, `TX_FLUSH_BIT);
            RX_FIFO_FLUSH <= wr_soft &&
                             flush_bit(wr_data, `RX_FLUSH_BIT);
            RTS_WRITE       <= wr_rts;
            if (wr_rts) begin
                RTS_WRITE_VALUE <= wr_data[`RTS_MIRROR_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // UART reset output
    // ----------------------------------------------------------------
    // The UART's own reset follows the synchronised release, so a soft
    // reset holds the rest of the UART low for the whole sync window.
    always @(posedge CLK or negedge rstn) begin
        if (!rstn) begin
            UART_RSTN <= 1'b0;
        end else begin
            UART_RSTN <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    reg [31:0] next_rdata;
    reg [1:0]  next_rresp;

    always @* begin
        next_rdata = 32'h00000000;
        next_rresp = `RESP_OKAY;
        case (ARADDR)
        `RX_LEVEL_OFFSET: begin
            next_rdata[`RX_LEVEL_MSB:0] = RX_FIFO_COUNT;
        end
        `SOFT_RESET_OFFSET: begin
            next_rdata = 32'h00000000;
        end
        `RTS_MIRROR_OFFSET: begin
            next_rdata[`RTS_MIRROR_BIT] = RTS_CONTROL;
        end
        default: begin
            next_rresp = `RESP_SLVERR;
        end
        endcase
    end

    always @(posedge CLK or negedge rstn) begin
        if (!rstn) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h00000000;
            RRESP   <= `RESP_OKAY;
        end else begin
            // ARREADY is a one-cycle pulse and ARADDR is decoded live in
            // it, so the master must hold the address until it sees ready.
            ARREADY <= ~RVALID & ~ARREADY & ARVALID;
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RDATA  <= next_rdata;
                RRESP  <= next_rresp;
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

endmodule // uart_shadow_regs

// ---- uart_shadow_props.sv ----
/* Assertions on the UART shadow register slave, bound to its ports.
   Assumes AW and W are offered together with the low strobe set. */
`timescale 1ns/1ps
module uart_shadow_props (
    input wire logic        CLK, RSTN, AWVALID, AWREADY, WVALID, WREADY,
    input wire logic        ARVALID, ARREADY, RVALID, RTS_CONTROL, RTS_WRITE,
    input wire logic        RTS_WRITE_VALUE, UART_RSTN, TX_FIFO_FLUSH,
    input wire logic        RX_FIFO_FLUSH,
    input wire logic [7:0]  AWADDR, ARADDR,
    input wire logic [4:0]  RX_FIFO_COUNT,
    input wire logic [31:0] WDATA, RDATA
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence s_wr(a); AWVALID && AWREADY && WVALID && WREADY && AWADDR == a;
    endsequence
    sequence s_rd(a); ARVALID && ARREADY && ARADDR == a; endsequence
    a_level_read: assert property (s_rd(8'h84) |=> RVALID &&
        RDATA == {27'h0, $past(RX_FIFO_COUNT)}) else $error("level read");
    a_reset_reg_read: assert property (s_rd(8'h88) |=>
        RVALID && RDATA == 32'h0) else $error("reset reg read");
    a_rts_read: assert property (s_rd(8'h8c) |=> RVALID &&
        RDATA == {31'h0, $past(RTS_CONTROL)}) else $error("rts read");
    a_fifo_flush: assert property (s_wr(8'h88) |=>
        {29'h0, TX_FIFO_FLUSH, RX_FIFO_FLUSH, 1'b0} == ($past(WDATA) & 32'h6))
        else $error("flush pulse");
    a_full_reset: assert property (s_wr(8'h88) && WDATA[0] |=>
        ##[0:3] !UART_RSTN) else $error("full reset");
    a_rts_write: assert property (s_wr(8'h8c) |=> RTS_WRITE &&
        {31'h0, RTS_WRITE_VALUE} == ($past(WDATA) & 32'h1)) else $error("rts");
    a_flush_once: assert property (TX_FIFO_FLUSH || RX_FIFO_FLUSH |=>
        !TX_FIFO_FLUSH && !RX_FIFO_FLUSH) else $error("flush held");
    a_rst_release: assert property ($rose(RSTN) |->
        !UART_RSTN ##[1:4] UART_RSTN) else $error("reset release");
endmodule // uart_shadow_props
bind uart_shadow_regs uart_shadow_props u_props (.*);

// ---- tb_uart_fifo_level_soft_reset.sv ----
/* Bench for the UART shadow register slave over AXI4-Lite.
   Assumes default parameters and a 10 MHz clock. */
`timescale 1ns/1ps
module tb_uart_fifo_level_soft_reset;
    reg         CLK = 0, RSTN = 0, AWVALID = 0, WVALID = 0, BREADY = 0;
    reg         ARVALID = 0, RREADY = 0, RTS_CONTROL = 0;
    reg  [7:0]  AWADDR = 0, ARADDR = 0;
    reg  [3:0]  WSTRB = 4'h1;
    reg  [4:0]  RX_FIFO_COUNT = 0;
    reg  [31:0] WDATA = 0, d, e;
    reg  [1:0]  r;
    reg  [4:0]  p;
    wire        AWREADY, WREADY, BVALID, ARREADY, RVALID, RTS_WRITE;
    wire        RTS_WRITE_VALUE, TX_FIFO_FLUSH, RX_FIFO_FLUSH, UART_RSTN;
    wire [1:0]  BRESP, RRESP;
    wire [31:0] RDATA;
    integer     n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 45685, i;
    uart_shadow_regs uut (.*);
    initial forever #50 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch = n_mismatch + 1;
            summarize;
        end
    end
    task summarize;
        $display("mismatches %0d checks %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // A full reset swallows its own response, so wait for the reset
    task wr(input [7:0] a, input [31:0] v, input nob);
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= v;
        {AWVALID, WVALID, BREADY} <= 3'h7;
        forever begin
            @(posedge CLK);
            if (BVALID || (nob && !UART_RSTN)) begin
                r = BRESP;
                p = {UART_RSTN, RTS_WRITE_VALUE, RTS_WRITE, TX_FIFO_FLUSH,
                     RX_FIFO_FLUSH};
                {AWVALID, WVALID, BREADY} <= 3'h0;
                break;
            end
            if (AWREADY) AWVALID <= 0;
            if (WREADY) WVALID <= 0;
        end
        while (UART_RSTN !== 1'b1) @(posedge CLK);
    endtask
    task rd(input [7:0] a);
        @(posedge CLK);
        ARADDR <= a;
        {ARVALID, RREADY} <= 2'h3;
        forever begin
            @(posedge CLK);
            if (RVALID) begin
                d = RDATA;
                r = RRESP;
                RREADY <= 0;
                break;
            end
            if (ARREADY) ARVALID <= 0;
        end
    endtask
    initial begin
        repeat (5) @(posedge CLK);
        RSTN <= 1;
        repeat (3) @(posedge CLK);
        rd(8'h84);
        chk("reset out", UART_RSTN, 1);
        chk("level at reset", d, 0);
        for (i = 0; i < 24; i = i + 1) begin
            e = (i == 0) ? 32'h1f : $random(seed);
            RX_FIFO_COUNT <= e[4:0];
            RTS_CONTROL <= e[5];
            rd(8'h84);
            chk("level", d, e[4:0]);
            rd(8'h8c);
            chk("rts read", d, e[5]);
            rd(8'h88);
            chk("reset reg read", d, 0);
            wr(8'h88, e & 32'h6, 0);
            chk("flush", p & 5'h17, {3'h4, e[2:1]});
            wr(8'h8c, e >> 6, 0);
            chk("rts load", p, {1'b1, e[6], 3'h4});
            wr(8'h84, e, 0);
            chk("level write resp", r, 0);
            chk("level write pulses", p & 5'h17, 5'h10);
        end
        rd(8'h90);
        chk("unmapped resp", r, 2'h2);
        chk("unmapped data", d, 0);
        wr(8'h88, 1, 1);
        chk("full reset outputs", p, 0);
        rd(8'h84);
        chk("level after reset", d, e[4:0]);
        summarize;
    end
endmodule // tb_uart_fifo_level_soft_reset
